// ---- rtl/css_regs.svh ----
// Purpose: Constants for the configuration status sequencer
// Assumes: 10 MHz system clock
// Notes:   Offsets, fields, event bits and timing counts
`ifndef CSS_REGS_SVH
`define CSS_REGS_SVH

// Register word indices (byte address = index * 4)
`define CSS_REG_CTRL      4'h0
`define CSS_REG_STATUS    4'h1
`define CSS_REG_IRQ_STAT  4'h2
`define CSS_REG_IRQ_MASK  4'h3

// Control fields
`define CSS_CTRL_ERR      0
`define CSS_CTRL_DATA_OK  1
`define CSS_CTRL_PU_INIT  2
`define CSS_CTRL_PU_DONE  3
`define CSS_CTRL_PU_RST   4
`define CSS_CTRL_PU_CLK   5
`define CSS_CTRL_CLR_DONE 6
`define CSS_CTRL_W        7

// Event bits
`define CSS_EV_INIT_END   0
`define CSS_EV_CFG_START  1
`define CSS_EV_ERROR      2
`define CSS_EV_CFG_DONE   3
`define CSS_EV_RESTART    4
`define CSS_EV_W          5

// Clear time: 2 us at 100 ns per cycle
`define CSS_CLEAR_NS      2000
`define CSS_CLK_NS        100
`define CSS_CLEAR_CYC     ((`CSS_CLEAR_NS + `CSS_CLK_NS - 1) / `CSS_CLK_NS)
`define CSS_CNT_W         8
`define CSS_MCLK_DIV      4'h3
`define CSS_STARTUP_CYC   8'h08

`endif

// ---- rtl/css_pkg.sv ----
// Purpose: Types for the configuration status sequencer
// Assumes: Nothing beyond the register header
// Notes:   Mode codes follow the three select pins directly
`default_nettype none
package css_pkg;
  typedef enum logic [2:0] {
    CSS_MODE_MSPI  = 3'h0,
    CSS_MODE_SSER  = 3'h1,
    CSS_MODE_SPAR  = 3'h2,
    CSS_MODE_JTAG  = 3'h3,
    CSS_MODE_RSV4  = 3'h4,
    CSS_MODE_RSV5  = 3'h5,
    CSS_MODE_RSV6  = 3'h6,
    CSS_MODE_RSV7  = 3'h7
  } css_mode_t;

  typedef enum logic [2:0] {
    CSS_ST_POWER,
    CSS_ST_CLEAR,
    CSS_ST_WAIT_INIT,
    CSS_ST_CONFIG,
    CSS_ST_ERROR,
    CSS_ST_STARTUP,
    CSS_ST_USER
  } css_state_t;

  typedef struct packed {
    logic oe;
    logic o;
    logic pu;
  } css_pin_t;
endpackage
`default_nettype wire

// ---- rtl/css_sequencer.sv ----
// Purpose: Init, configuration and start-up sequencing of the config pins
// Assumes: Pins are two-flop synchronised here; bus on clk
// Notes:   Open-drain pins drive low only; release means oe low
//
// Summary of operation
// R01: During clearing all general pins tri-stated, pull-ups when select input low.
// R02: During configuration general pins tri-stated except config pins, same pull-up rule.
// R03: Drive init-status low after power-up, release it when initialization ends.
// R04: Outside party may hold init-status low; configuration waits while it stays low.
// R05: Start configuration once init-status is sampled high after initialization.
// R06: While configuring, drive init-status low whenever a configuration error occurred.
// R07: Hold config-done low until data received correctly and start-up begins.
// R08: High config-done level means configuration is complete.
// R09: Outside low on config-done halts start-up until it returns high.
// R10: Low restart pin empties configuration memory then reconfigures.
// R11: Restart falling edge resets config logic; rising edge starts configuration.
// R12: Restart held low during power-up is not a configuration reset.
// R13: Configuration runs synchronously to the configuration clock except JTAG mode.
// R14: Slave modes take configuration clock as input from outside controller.
// R15: Master flash mode drives configuration clock as an output.
// R16: Configuration clock pin high impedance when no clock is needed.
// R17: Mode chosen from three dedicated mode-select inputs.
// R18: After configuration apply user pull-up or float on four dedicated pins.
// R19: Mode sampled once when configuration begins, held until restart or power-up.
//
// Implementation choices: strobed register access and the placing of the registers.
`include "css_regs.svh"
`default_nettype none
module css_sequencer
  import css_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic [3:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            irq,
  input  wire logic       init_flag_n_i,
  output logic            init_flag_n_o,
  output logic            init_flag_n_oe,
  output logic            init_flag_n_pu,
  input  wire logic       cfg_done_i,
  output logic            cfg_done_o,
  output logic            cfg_done_oe,
  output logic            cfg_done_pu,
  input  wire logic       config_restart_n,
  output logic            restart_pu,
  input  wire logic       cfg_clk_i,
  output logic            cfg_clk_o,
  output logic            cfg_clk_oe,
  output logic            cfg_clk_pu,
  input  wire logic [2:0] mode_sel,
  input  wire logic       idle_pullup_sel,
  output logic            gpio_tristate,
  output logic            gpio_pullup,
  output logic            cfg_pins_active,
  output logic            cfg_tick,
  output logic            clear_mem,
  output logic            user_mode
);

  // ==========================================================
  // Pin synchronisers
  logic [1:0] init_s_r, done_s_r, rst_s_r, cclk_s_r, idle_s_r;
  logic [2:0] mode_s1_r, mode_s2_r;
  logic       rst_d_r, cclk_d_r;
  logic [2:0] rst_arm_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_s_r  <= 2'h0;
      done_s_r  <= 2'h0;
      rst_s_r   <= 2'h3;
      // Seeded at the idle-high pin level: no false edge after reset
      cclk_s_r  <= 2'h3;
      idle_s_r  <= 2'h0;
      mode_s1_r <= 3'h0;
      mode_s2_r <= 3'h0;
      rst_d_r   <= 1'h1;
      cclk_d_r  <= 1'h1;
      rst_arm_r <= 3'h0;
    end else begin
      init_s_r  <= {init_s_r[0], init_flag_n_i};
      done_s_r  <= {done_s_r[0], cfg_done_i};
      rst_s_r   <= {rst_s_r[0], config_restart_n};
      cclk_s_r  <= {cclk_s_r[0], cfg_clk_i};
      idle_s_r  <= {idle_s_r[0], idle_pullup_sel};
      mode_s1_r <= mode_sel;
      mode_s2_r <= mode_s1_r;
      rst_d_r   <= rst_s_r[1];
      cclk_d_r  <= cclk_s_r[1];
      rst_arm_r <= {rst_arm_r[1:0], 1'h1};
    end
  end

  logic init_hi, done_hi, rst_fall, rst_rise, cclk_rise;
  assign init_hi   = init_s_r[1];
  assign done_hi   = done_s_r[1];
  // Edges count only once the chain holds the real pin: low at power-up is no restart
  assign rst_fall  = rst_arm_r[2] & rst_d_r & ~rst_s_r[1];  // [R12]
  assign rst_rise  = rst_arm_r[2] & ~rst_d_r & rst_s_r[1];  // [R12]
  assign cclk_rise = ~cclk_d_r & cclk_s_r[1];

  // ==========================================================
  // Registers
  logic [`CSS_CTRL_W-1:0] ctrl_r;
  logic [`CSS_EV_W-1:0]   ev_stat_r, ev_mask_r, ev_set;
  css_state_t             state_r;
  css_mode_t              mode_r;
  logic                   clr_w1c, err_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_r    <= '0;
      ev_mask_r <= '0;
    end else if (reg_wr) begin
      if (reg_addr == `CSS_REG_CTRL)
        ctrl_r <= reg_wdata[`CSS_CTRL_W-1:0];
      if (reg_addr == `CSS_REG_IRQ_MASK)
        ev_mask_r <= reg_wdata[`CSS_EV_W-1:0];
    end
  end

  assign clr_w1c = reg_wr && (reg_addr == `CSS_REG_IRQ_STAT);

  // Set wins over a simultaneous write-one clear
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      ev_stat_r <= '0;
    else if (clr_w1c)
      ev_stat_r <= (ev_stat_r & ~reg_wdata[`CSS_EV_W-1:0]) | ev_set;
    else
      ev_stat_r <= ev_stat_r | ev_set;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      irq <= 1'h0;
    else
      irq <= |(ev_stat_r & ev_mask_r);
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `CSS_REG_CTRL:     reg_rdata <= {1'h0, ctrl_r};
        `CSS_REG_STATUS:   reg_rdata <= {user_mode, err_r, mode_r, state_r};
        `CSS_REG_IRQ_STAT: reg_rdata <= {3'h0, ev_stat_r};
        `CSS_REG_IRQ_MASK: reg_rdata <= {3'h0, ev_mask_r};
        default:           reg_rdata <= 8'h00;
      endcase
    end else begin
      reg_rdata <= 8'h00;
    end
  end

  // ==========================================================
  // Master clock divider, one-cycle enable
  logic [3:0] div_r;
  logic       mclk_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      div_r  <= 4'h0;
      mclk_r <= 1'h0;
    end else if (div_r == `CSS_MCLK_DIV) begin
      div_r  <= 4'h0;
      mclk_r <= ~mclk_r;
    end else begin
      div_r <= div_r + 4'h1;
    end
  end

  logic tick;
  always_comb begin
    case (mode_r)
      CSS_MODE_MSPI: tick = (div_r == `CSS_MCLK_DIV) & ~mclk_r; // [R15]
      CSS_MODE_SSER,
      CSS_MODE_SPAR: tick = cclk_rise;                           // [R13] [R14]
      default:       tick = 1'h0;
    endcase
  end

  // ==========================================================
  // Sequencer
  logic [`CSS_CNT_W-1:0] cnt_r;
  logic                  in_cfg;
  assign in_cfg = (state_r == CSS_ST_CONFIG) || (state_r == CSS_ST_ERROR);

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_r <= CSS_ST_POWER;
      cnt_r   <= '0;
      mode_r  <= CSS_MODE_MSPI;
      err_r   <= 1'h0;
    end else begin
      case (state_r)
        // Restart held low at power-up is ignored: only edges count
        CSS_ST_POWER: begin                                      // [R12]
          state_r <= CSS_ST_CLEAR;
          cnt_r   <= '0;
        end
        CSS_ST_CLEAR: begin
          if (cnt_r == `CSS_CNT_W'(`CSS_CLEAR_CYC - 1))
            state_r <= CSS_ST_WAIT_INIT;
          else
            cnt_r <= cnt_r + `CSS_CNT_W'(1);
        end
        CSS_ST_WAIT_INIT: begin
          if (init_hi) begin                                     // [R04] [R05]
            state_r <= CSS_ST_CONFIG;
            mode_r  <= css_mode_t'(mode_s2_r);                   // [R17] [R19]
            err_r   <= 1'h0;
          end
        end
        CSS_ST_CONFIG: begin
          if (ctrl_r[`CSS_CTRL_ERR]) begin
            state_r <= CSS_ST_ERROR;
            err_r   <= 1'h1;
          end else if (ctrl_r[`CSS_CTRL_DATA_OK] && (tick || mode_r == CSS_MODE_JTAG)) begin
            state_r <= CSS_ST_STARTUP;
            cnt_r   <= '0;
          end
        end
        CSS_ST_ERROR: state_r <= CSS_ST_ERROR;
        CSS_ST_STARTUP: begin
          if (done_hi) begin                                     // [R09]
            if (cnt_r == `CSS_STARTUP_CYC)
              state_r <= CSS_ST_USER;
            else
              cnt_r <= cnt_r + `CSS_CNT_W'(1);
          end
        end
        CSS_ST_USER: state_r <= CSS_ST_USER;
        default: state_r <= CSS_ST_POWER;
      endcase
      if (rst_fall) begin                                        // [R10] [R11]
        state_r <= CSS_ST_CLEAR;
        cnt_r   <= '0;
      end else if (hold_clear_r && state_r == CSS_ST_CLEAR) begin // [R10]
        cnt_r <= '0;
      end
    end
  end

  // Restart low holds clearing; rise lets it finish and start config
  logic hold_clear_r;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst)
      hold_clear_r <= 1'h0;
    else if (rst_fall)
      hold_clear_r <= 1'h1;
    else if (rst_rise)                                           // [R11]
      hold_clear_r <= 1'h0;
  end

  assign ev_set[`CSS_EV_INIT_END]  = (state_r == CSS_ST_CLEAR) && !hold_clear_r &&
                                     (cnt_r == `CSS_CNT_W'(`CSS_CLEAR_CYC - 1));
  assign ev_set[`CSS_EV_CFG_START] = (state_r == CSS_ST_WAIT_INIT) && init_hi;
  assign ev_set[`CSS_EV_ERROR]     = (state_r == CSS_ST_CONFIG) && ctrl_r[`CSS_CTRL_ERR];
  assign ev_set[`CSS_EV_CFG_DONE]  = (state_r == CSS_ST_STARTUP) && done_hi &&
                                     (cnt_r == `CSS_STARTUP_CYC);
  assign ev_set[`CSS_EV_RESTART]   = rst_fall;

  // ==========================================================
  // Pin drives
  logic clear_st;
  assign clear_st = (state_r == CSS_ST_POWER) || (state_r == CSS_ST_CLEAR) || hold_clear_r;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_flag_n_oe <= 1'h1;
      cfg_done_oe    <= 1'h1;
      cfg_clk_oe     <= 1'h0;
      cfg_clk_o      <= 1'h0;
    end else begin
      init_flag_n_oe <= clear_st || (state_r == CSS_ST_ERROR);   // [R03] [R06]
      cfg_done_oe    <= !((state_r == CSS_ST_STARTUP) || (state_r == CSS_ST_USER)) ||
                        ctrl_r[`CSS_CTRL_CLR_DONE];              // [R07] [R08]
      cfg_clk_oe     <= in_cfg && (mode_r == CSS_MODE_MSPI);     // [R15] [R16]
      cfg_clk_o      <= mclk_r;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      init_flag_n_o   <= 1'h0;
      cfg_done_o      <= 1'h0;
      init_flag_n_pu  <= 1'h0;
      cfg_done_pu     <= 1'h1;
      restart_pu      <= 1'h1;
      cfg_clk_pu      <= 1'h0;
      gpio_tristate   <= 1'h1;
      gpio_pullup     <= 1'h0;
      cfg_pins_active <= 1'h0;
      cfg_tick        <= 1'h0;
      clear_mem       <= 1'h1;
      user_mode       <= 1'h0;
    end else begin
      init_flag_n_o   <= 1'h0;
      cfg_done_o      <= 1'h0;
      // User pull-up choices take over once configured
      init_flag_n_pu  <= (state_r == CSS_ST_USER) ? ctrl_r[`CSS_CTRL_PU_INIT] : in_cfg; // [R18]
      cfg_done_pu     <= (state_r == CSS_ST_USER) ? ctrl_r[`CSS_CTRL_PU_DONE] : 1'h1;   // [R18]
      restart_pu      <= (state_r == CSS_ST_USER) ? ctrl_r[`CSS_CTRL_PU_RST]  : 1'h1;   // [R18]
      cfg_clk_pu      <= (state_r == CSS_ST_USER) ? ctrl_r[`CSS_CTRL_PU_CLK]  : 1'h0;   // [R18]
      gpio_tristate   <= (state_r != CSS_ST_USER);                // [R01] [R02]
      gpio_pullup     <= (state_r != CSS_ST_USER) && !idle_s_r[1]; // [R01] [R02]
      cfg_pins_active <= in_cfg && (mode_r != CSS_MODE_JTAG);    // [R02]
      cfg_tick        <= in_cfg && tick;                         // [R13]
      clear_mem       <= clear_st;                               // [R10]
      user_mode       <= (state_r == CSS_ST_USER);
    end
  end

  // ==========================================================
  // Assertions
  a_wait_holds_init: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == CSS_ST_WAIT_INIT && !init_hi && !rst_fall) |=> state_r == CSS_ST_WAIT_INIT) // [R04]
    else $error("Configuration began while init held low");
  a_init_starts_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == CSS_ST_WAIT_INIT && init_hi && !rst_fall) |=> state_r == CSS_ST_CONFIG) // [R05]
    else $error("Configuration did not start on init high");
  a_error_drives_low: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == CSS_ST_ERROR && !hold_clear_r) |=> init_flag_n_oe) // [R06]
    else $error("Error not shown on init line");
  a_clear_drives_init: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == CSS_ST_CLEAR |=> init_flag_n_oe) // [R03]
    else $error("Init line released during clearing");
  a_done_held_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    in_cfg |=> cfg_done_oe) // [R07]
    else $error("Config-done released during configuration");
  a_startup_halts: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == CSS_ST_STARTUP && !done_hi && !rst_fall) |=> state_r == CSS_ST_STARTUP && $stable(cnt_r)) // [R09]
    else $error("Start-up advanced with done held low");
  a_restart_clears: assert property (@(posedge clk) disable iff (sys_rst)
    rst_fall |=> state_r == CSS_ST_CLEAR ##1 clear_mem) // [R11]
    else $error("Restart falling edge did not clear");
  a_clk_hiz_jtag: assert property (@(posedge clk) disable iff (sys_rst)
    (mode_r != CSS_MODE_MSPI) [*2] |-> !cfg_clk_oe) // [R16]
    else $error("Config clock driven outside master mode");
  a_mode_stable: assert property (@(posedge clk) disable iff (sys_rst)
    (in_cfg && $past(in_cfg)) |-> $stable(mode_r)) // [R19]
    else $error("Mode changed during configuration");
  a_gpio_pullup: assert property (@(posedge clk) disable iff (sys_rst)
    (clear_st && idle_s_r[1]) |=> !gpio_pullup) // [R01]
    else $error("Pull-up enabled with select high");
  a_cfg_tristate: assert property (@(posedge clk) disable iff (sys_rst)
    in_cfg |=> gpio_tristate) // [R02]
    else $error("General pins driven during configuration");
  a_done_released: assert property (@(posedge clk) disable iff (sys_rst)
    (state_r == CSS_ST_USER && !ctrl_r[`CSS_CTRL_CLR_DONE]) |=> !cfg_done_oe) // [R08]
    else $error("Config-done held low after configuration");
  a_hold_clears: assert property (@(posedge clk) disable iff (sys_rst)
    hold_clear_r |=> clear_mem) // [R10]
    else $error("Memory not cleared while restart low");
  a_powerup_no_restart: assert property (@(posedge clk) disable iff (sys_rst)
    !rst_arm_r[2] |=> !hold_clear_r) // [R12]
    else $error("Restart level at power-up taken as reset");
  a_tick_in_cfg: assert property (@(posedge clk) disable iff (sys_rst)
    !in_cfg |=> !cfg_tick) // [R13]
    else $error("Configuration tick outside configuration");
  a_master_clk_out: assert property (@(posedge clk) disable iff (sys_rst)
    (in_cfg && mode_r == CSS_MODE_MSPI) |=> cfg_clk_oe) // [R15]
    else $error("Config clock not driven in master mode");
  a_user_pullups: assert property (@(posedge clk) disable iff (sys_rst)
    state_r == CSS_ST_USER |=> init_flag_n_pu == $past(ctrl_r[`CSS_CTRL_PU_INIT])) // [R18]
    else $error("User pull-up choice not applied");

endmodule
`default_nettype wire

// ---- verification/css_partner.sv ----
// Purpose: Board-side model of the configuration controller and its lines
// Assumes: External pull-ups on both open-drain lines; the link clock drives the clock pin when it is released
// Notes:   Link clock stands still between frames, idling high
`default_nettype none
module css_partner (
  input  wire logic clk_run,
  input  wire logic hold_init,
  input  wire logic hold_done,
  input  wire logic init_flag_n_oe,
  input  wire logic init_flag_n_o,
  input  wire logic cfg_done_oe,
  input  wire logic cfg_done_o,
  input  wire logic cfg_clk_oe,
  input  wire logic cfg_clk_o,
  output logic      init_flag_n_i,
  output logic      cfg_done_i,
  output logic      cfg_clk_i
);
  timeunit 1ns;
  timeprecision 1ps;
  logic lclk = 1'b1;
  // =====================================
  // Link clock, 800 ns, phase unrelated to clk
  initial begin
    #137;
    forever begin
      #400;
      if (clk_run || !lclk) lclk = ~lclk;
    end
  end
  // =====================================
  // Wired levels
  assign init_flag_n_i = !(init_flag_n_oe && !init_flag_n_o) && !hold_init;
  assign cfg_done_i    = !(cfg_done_oe && !cfg_done_o) && !hold_done;
  assign cfg_clk_i     = cfg_clk_oe ? cfg_clk_o : lclk;
endmodule
`default_nettype wire

// ---- verification/config_status_sequencer_bench.sv ----
// Purpose: Self-checking bench for the configuration status sequencer
// Assumes: Partner model closes the open-drain lines and the link clock
// Notes:   Read results are matched against a queue of expected values
`include "css_regs.svh"
`default_nettype none
module config_status_sequencer_bench
  import css_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0, sys_rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, rd_d = 1'b0;
  logic config_restart_n = 1'b0, idle_pullup_sel = 1'b0;
  logic hold_init = 1'b1, hold_done = 1'b0, clk_run = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic [2:0] mode_sel = 3'h1;
  logic [7:0] reg_rdata;
  logic irq, init_flag_n_o, init_flag_n_oe, init_flag_n_pu, cfg_done_o, cfg_done_oe, cfg_done_pu;
  logic restart_pu, cfg_clk_o, cfg_clk_oe, cfg_clk_pu, gpio_tristate, gpio_pullup;
  logic cfg_pins_active, cfg_tick, clear_mem, user_mode;
  wire logic init_flag_n_i, cfg_done_i, cfg_clk_i;
  int error_cnt = 0, checks_done = 0, seed = 21029, r;
  logic [7:0] exp_q[$], msk_q[$];

  css_sequencer dut (.clk, .sys_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .irq,
    .init_flag_n_i, .init_flag_n_o, .init_flag_n_oe, .init_flag_n_pu, .cfg_done_i, .cfg_done_o,
    .cfg_done_oe, .cfg_done_pu, .config_restart_n, .restart_pu, .cfg_clk_i, .cfg_clk_o, .cfg_clk_oe,
    .cfg_clk_pu, .mode_sel, .idle_pullup_sel, .gpio_tristate, .gpio_pullup, .cfg_pins_active,
    .cfg_tick, .clear_mem, .user_mode);
  css_partner u_partner (.clk_run, .hold_init, .hold_done, .init_flag_n_oe, .init_flag_n_o,
    .cfg_done_oe, .cfg_done_o, .cfg_clk_oe, .cfg_clk_o, .init_flag_n_i, .cfg_done_i, .cfg_clk_i);

  always #50 clk = ~clk;

  // =====================================
  // Reporting
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // =====================================
  // Register bus and read watcher
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e, input logic [7:0] m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    exp_q.push_back(e & m);
    msk_q.push_back(m);
    @(posedge clk);
    reg_rd <= 1'b0;
  endtask
  always @(posedge clk) begin
    rd_d <= reg_rd;
    if (rd_d) chk("reg_rdata", reg_rdata & msk_q.pop_front(), exp_q.pop_front());
  end
  // =====================================
  // Bounded waits on design outputs
  function automatic logic sig(input int w);
    case (w)
      0: return clear_mem;
      1: return user_mode;
      2: return cfg_done_oe;
      3: return init_flag_n_oe;
      4: return cfg_tick;
      default: return cfg_pins_active;
    endcase
  endfunction
  task automatic wait_for(input int w, input logic lvl, input int bound);
    int n;
    n = 0;
    @(negedge clk);
    while (sig(w) !== lvl && n < bound) begin
      @(negedge clk);
      n++;
    end
    if (n >= bound) begin
      error_cnt++;
      $display("CHECK FAILED wait %0d expected %b seen timeout", w, lvl);
      end_sim();
    end
  endtask
  task automatic restart(input logic [2:0] m);
    r = $random(seed);
    mode_sel <= m;
    idle_pullup_sel <= r[0];
    config_restart_n <= 1'b0;
    wait_for(0, 1'b1, 10);
    chk("init_oe", init_flag_n_oe, 8'h01);
    chk("gpio_pu", gpio_pullup, {7'h00, ~idle_pullup_sel});
    repeat (30) @(negedge clk);
    chk("clear_held", clear_mem, 8'h01);
    config_restart_n <= 1'b1;
    wait_for(0, 1'b0, 40);
  endtask

  // =====================================
  // Main sequence
  initial begin
    repeat (19) @(negedge clk);
    chk("init_oe", init_flag_n_oe, 8'h01);
    chk("done_oe", cfg_done_oe, 8'h01);
    chk("gpio_ts", gpio_tristate, 8'h01);
    @(posedge clk);
    sys_rst <= 1'b0;
    repeat (15) @(negedge clk);
    config_restart_n <= 1'b1;
    chk("clear", clear_mem, 8'h01);
    chk("gpio_pu", gpio_pullup, {7'h00, ~idle_pullup_sel});
    wait_for(0, 1'b0, 40);
    repeat (3) @(negedge clk);
    chk("init_oe", init_flag_n_oe, 8'h00);
    repeat (20) @(negedge clk);
    rd(`CSS_REG_STATUS, 8'h02, 8'h07);
    hold_init <= 1'b0;
    wait_for(5, 1'b1, 10);
    mode_sel <= 3'h2;
    rd(`CSS_REG_STATUS, 8'h0b, 8'h3f);
    chk("clk_oe", cfg_clk_oe, 8'h00);
    chk("gpio_ts", gpio_tristate, 8'h01);
    chk("gpio_pu", gpio_pullup, {7'h00, ~idle_pullup_sel});
    rd(`CSS_REG_IRQ_STAT, 8'h03, 8'h1f);
    wr(`CSS_REG_IRQ_MASK, 8'h02);
    repeat (3) @(negedge clk);
    chk("irq", irq, 8'h01);
    wr(`CSS_REG_IRQ_STAT, 8'h03);
    repeat (3) @(negedge clk);
    chk("irq", irq, 8'h00);
    rd(4'h9, 8'h00, 8'hff);
    wr(`CSS_REG_CTRL, 8'h3e);
    repeat (20) @(negedge clk);
    chk("done_oe", cfg_done_oe, 8'h01);
    hold_done <= 1'b1;
    clk_run <= 1'b1;
    wait_for(4, 1'b1, 40);
    wait_for(2, 1'b0, 40);
    repeat (20) @(negedge clk);
    chk("user", user_mode, 8'h00);
    hold_done <= 1'b0;
    clk_run <= 1'b0;
    wait_for(1, 1'b1, 30);
    chk("gpio_ts", gpio_tristate, 8'h00);
    chk("pins_pu", {init_flag_n_pu, cfg_done_pu, restart_pu, cfg_clk_pu}, 8'h0f);
    wr(`CSS_REG_CTRL, 8'h3c);
    restart(3'h0);
    wait_for(5, 1'b1, 10);
    chk("clk_oe", cfg_clk_oe, 8'h01);
    wait_for(4, 1'b1, 40);
    rd(`CSS_REG_IRQ_STAT, 8'h10, 8'h10);
    wr(`CSS_REG_CTRL, 8'h01);
    wait_for(3, 1'b1, 10);
    rd(`CSS_REG_STATUS, 8'h44, 8'h7f);
    wr(`CSS_REG_CTRL, 8'h00);
    restart(3'h3);
    repeat (5) @(negedge clk);
    chk("clk_oe", cfg_clk_oe, 8'h00);
    chk("init_oe", init_flag_n_oe, 8'h00);
    wr(`CSS_REG_CTRL, 8'h02);
    wait_for(2, 1'b0, 20);
    repeat (3) @(negedge clk);
    end_sim();
  end
endmodule
`default_nettype wire
